// >>> src/bms_params.svh
// constants for the boot mode select and manufacturing test block
// assumes byte layouts of the bulk-only command wrapper and test image
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH
// eeprom signatures
`define BMS_SIG_LEGACY 16'h4d4d
`define BMS_SIG_NORMAL 16'h534b
// vendor sub-commands and fixed fields
`define BMS_SUB_CFG 8'h26
`define BMS_SUB_PIN 8'h27
`define BMS_SRC_EEPROM 8'h02
`define BMS_CFG_MAX_LEN 32'h0000_00ff
// command block byte positions
`define BMS_CB_DESIG 0
`define BMS_CB_SUB 1
`define BMS_CB_RSV 2
`define BMS_CB_SRC 3
`define BMS_CB_ADDR 4
`define BMS_CB_LAST 15
// wrapper byte positions
`define BMS_CBW_LEN0 5'h08
`define BMS_CBW_LEN3 5'h0b
`define BMS_CBW_FLAGS 5'h0c
`define BMS_CBW_CB0 5'h0f
`define BMS_CBW_LAST 5'h1e
`define BMS_DIR_BIT 7
// test image layout: byte k bit j sits at bit 8k+j
`define BMS_IMG_MFG_SEL 14
`define BMS_IMG_DD_OE 15
`define BMS_IMG_DD_LO 16
// control pin order: diow,dior,dmack,da1,da0,drvpwr,cs1,cs0,ata_reset_line_n
`define BMS_CTL_MAP(m) {m[8], m[9], m[10], m[2], m[1], m[3], m[5], m[4], m[7]}
`define BMS_SYNC_FILL 2'h3
`endif

// >>> src/bms_pkg.sv
// types for the boot mode select and manufacturing test block
// assumes nothing beyond a SystemVerilog tool
package bms_pkg;
    typedef enum logic [1:0] {bms_b_fill, bms_b_probe, bms_b_run} bms_boot_t;
    typedef enum logic [1:0] {bms_c_cbw, bms_c_dec, bms_c_load,
        bms_c_read} bms_cmd_st_t;
    typedef enum logic [2:0] {bms_k_none, bms_k_cfg_load, bms_k_cfg_read,
        bms_k_pin_load, bms_k_pin_read} bms_kind_t;
endpackage

// >>> src/bms_pin_ctrl.sv
// pin override for interconnect test: holds the loaded test image
// assumes load strobes from the command decoder on the same clock
`timescale 1ns/10ps
`include "bms_params.svh"
module bms_pin_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // image load
    input wire logic load_valid,
    input wire logic [1:0] load_idx,
    input wire logic [7:0] load_byte,
    input wire logic test_active,
    // normal bridge drive
    input wire logic [8:0] norm_ctl,
    input wire logic [8:0] norm_ctl_oe,
    input wire logic [15:0] norm_dd,
    input wire logic norm_dd_oe,
    // pins
    output logic [8:0] ctl_out,
    output logic [8:0] ctl_oe,
    output logic [15:0] dd_out,
    output logic dd_oe
);
    logic [31:0] image;

    // image bytes; zero until the host loads one
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            image <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (load_valid && load_idx == 2'(i)) begin
                    image[8*i +: 8] <= load_byte;
                end
            end
        end
    end

    // test mode takes every non-usb output away from the bridge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl_out <= 9'h000;
            ctl_oe <= 9'h000;
            dd_out <= 16'h0000;
            dd_oe <= 1'b0;
        end else if (test_active) begin
            ctl_out <= `BMS_CTL_MAP(image);
            ctl_oe <= 9'h1ff;
            dd_out <= image[`BMS_IMG_DD_LO +: 16];
            dd_oe <= image[`BMS_IMG_DD_OE];
        end else begin
            ctl_out <= norm_ctl;
            ctl_oe <= norm_ctl_oe;
            dd_out <= norm_dd;
            dd_oe <= norm_dd_oe;
        end
    end

    AST_DD_HIZ: assert property (@(posedge clk_sys) disable iff (srst)
        test_active && $past(test_active) && !image[`BMS_IMG_DD_OE]
        |=> !dd_oe)
        else $error("data bus driven while image asks high impedance");
endmodule

// >>> src/bms_top.sv
// boot mode selection and manufacturing test command decoder
// assumes i2c probe engine, usb bulk pipe and eeprom engine on clk_sys
`timescale 1ns/10ps
`include "bms_params.svh"
module bms_top #(
    parameter bit LEGACY_OK = 1'b1,
    parameter int PIN_BYTES = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // eeprom probe and fuses
    output logic eep_probe_req,
    input wire logic eep_probe_done,
    input wire logic eep_present,
    input wire logic [15:0] eep_signature,
    input wire logic fuse_ids_zero,
    // pins sampled from outside
    input wire logic ata_reset_line_n_in,
    input wire logic [31:0] sample_pins_in,
    // selected mode
    output logic boot_done,
    output logic usb_enum_en,
    output logic cfg_from_eeprom,
    output logic cfg_from_fuse,
    output logic legacy_pinout,
    output logic default_desc,
    output logic mfg_mode,
    output logic pin_test_active,
    // wrapper bytes from bulk pipe
    input wire logic cbw_valid,
    input wire logic cbw_first,
    input wire logic [7:0] cbw_byte,
    output logic cbw_ready,
    input wire logic [7:0] vendor_command_designator,
    // command result
    output logic cmd_done,
    output logic cmd_vendor,
    output logic cmd_fail,
    output bms_pkg::bms_kind_t cmd_kind,
    output logic [31:0] cmd_len,
    // eeprom engine
    output logic eep_cmd_valid,
    output logic eep_cmd_read,
    output logic [7:0] eep_cmd_len,
    output logic eep_wr_valid,
    output logic [7:0] eep_wr_byte,
    // data stage
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    // ata side pins
    input wire logic [8:0] norm_ctl,
    input wire logic [8:0] norm_ctl_oe,
    input wire logic [15:0] norm_dd,
    input wire logic norm_dd_oe,
    output logic [8:0] ctl_out,
    output logic [8:0] ctl_oe,
    output logic [15:0] dd_out,
    output logic dd_oe
);
    if (PIN_BYTES < 1 || PIN_BYTES > 4) begin : g_bad
        $error("PIN_BYTES must be 1 to 4");
    end

    bms_pkg::bms_boot_t boot_st;
    bms_pkg::bms_cmd_st_t cmd_st;
    bms_pkg::bms_kind_t next_kind;
    logic [1:0] strap_sync;
    logic [31:0] pin_s1, pin_s2, live_snap, snap, xfer_len, remaining;
    logic [1:0] fill_cnt;
    logic [4:0] cbw_idx, cur_idx;
    logic [7:0] cb [16];
    logic [2:0] byte_idx;
    logic dir_in, decide, sig_norm, sig_leg, strap_ok, cbw_end;
    logic is_vendor, is_cfg, cfg_ok, pin_ok, cmd_good, rx_hs, tx_hs;
    logic pin_load;

    // true when command block bytes from 'from' to the end are zero
    function automatic logic cb_zero(input int from);
        logic z;
        z = 1'b1;
        for (int i = `BMS_CB_RSV; i <= `BMS_CB_LAST; i++) begin
            if (i >= from && cb[i] != 8'h00) begin
                z = 1'b0;
            end
        end
        return z;
    endfunction

    // snapshot byte, zero past the mapped bytes
    function automatic logic [7:0] snap_byte(input logic [31:0] v,
        input logic [2:0] i);
        return (32'(i) < PIN_BYTES) ? v[8*i +: 8] : 8'h00;
    endfunction

    // pins from outside pass two flops; the strap idles high
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            strap_sync <= 2'b11;
            pin_s1 <= 32'h0000_0000;
            pin_s2 <= 32'h0000_0000;
        end else begin
            strap_sync <= {strap_sync[0], ata_reset_line_n_in};
            pin_s1 <= sample_pins_in;
            pin_s2 <= pin_s1;
        end
    end
    assign strap_ok = strap_sync[1];

    // power-up: let the strap settle, then probe the eeprom
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            boot_st <= bms_pkg::bms_b_fill;
            fill_cnt <= 2'h0;
        end else begin
            case (boot_st)
                bms_pkg::bms_b_fill: begin
                    if (fill_cnt == `BMS_SYNC_FILL) begin
                        boot_st <= bms_pkg::bms_b_probe;
                    end else begin
                        fill_cnt <= fill_cnt + 2'h1;
                    end
                end
                bms_pkg::bms_b_probe: begin
                    if (eep_probe_done) begin
                        boot_st <= bms_pkg::bms_b_run;
                    end
                end
                bms_pkg::bms_b_run: begin
                end
                default: boot_st <= bms_pkg::bms_b_fill;
            endcase
        end
    end

    // enumeration waits until the mode is fixed
    assign eep_probe_req = (boot_st == bms_pkg::bms_b_probe);
    assign boot_done = (boot_st == bms_pkg::bms_b_run);
    assign usb_enum_en = boot_done;
    assign decide = eep_probe_req && eep_probe_done;
    assign sig_norm = (eep_signature == `BMS_SIG_NORMAL);
    assign sig_leg = LEGACY_OK && (eep_signature == `BMS_SIG_LEGACY);

    // configuration source, caught once at the probe result
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_from_eeprom <= 1'b0;
            cfg_from_fuse <= 1'b0;
            legacy_pinout <= 1'b0;
            default_desc <= 1'b0;
        end else if (decide) begin
            cfg_from_eeprom <= eep_present && (sig_norm || sig_leg);
            legacy_pinout <= eep_present && sig_leg;
            cfg_from_fuse <= !eep_present;
            default_desc <= !eep_present && fuse_ids_zero;
        end
    end

    // sticky: no command clears it, only srst
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mfg_mode <= 1'b0;
        end else if (decide && (!strap_ok
            || (eep_present && !sig_norm && !sig_leg)
            || (!eep_present && fuse_ids_zero))) begin
            mfg_mode <= 1'b1;
        end
    end

    // wrapper capture; cbw_first restarts the byte count
    assign cbw_ready = (cmd_st == bms_pkg::bms_c_cbw);
    assign cur_idx = cbw_first ? 5'h00 : cbw_idx;
    assign cbw_end = cbw_valid && cbw_ready && cur_idx == `BMS_CBW_LAST;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cbw_idx <= 5'h00;
            xfer_len <= 32'h0000_0000;
            dir_in <= 1'b0;
        end else if (cbw_valid && cbw_ready) begin
            cbw_idx <= cur_idx + 5'h01;
            if (cur_idx >= `BMS_CBW_LEN0 && cur_idx <= `BMS_CBW_LEN3) begin
                xfer_len[{cur_idx[1:0], 3'b000} +: 8] <= cbw_byte;
            end
            if (cur_idx == `BMS_CBW_FLAGS) begin
                dir_in <= cbw_byte[`BMS_DIR_BIT];
            end
        end
    end

    // command block bytes; data only, no reset needed
    always_ff @(posedge clk_sys) begin
        if (cbw_valid && cbw_ready && cur_idx >= `BMS_CBW_CB0) begin
            cb[4'(cur_idx - `BMS_CBW_CB0)] <= cbw_byte;
        end
    end

    // decode of the stored block
    assign is_vendor = mfg_mode
        && cb[`BMS_CB_DESIG] == vendor_command_designator
        && (cb[`BMS_CB_SUB] == `BMS_SUB_CFG
        || cb[`BMS_CB_SUB] == `BMS_SUB_PIN);
    assign is_cfg = (cb[`BMS_CB_SUB] == `BMS_SUB_CFG);
    // a process, so the helper's reads of cb wake it; an assign would not
    always_comb begin
        cfg_ok = cb[`BMS_CB_RSV] == 8'h00
            && cb[`BMS_CB_SRC] == `BMS_SRC_EEPROM && cb_zero(`BMS_CB_ADDR)
            && xfer_len <= `BMS_CFG_MAX_LEN;
        pin_ok = cb_zero(`BMS_CB_RSV);
    end
    assign cmd_good = is_cfg ? cfg_ok : pin_ok;
    assign next_kind = is_cfg
        ? (dir_in ? bms_pkg::bms_k_cfg_read : bms_pkg::bms_k_cfg_load)
        : (dir_in ? bms_pkg::bms_k_pin_read : bms_pkg::bms_k_pin_load);

    // data stage handshakes
    assign rx_ready = (cmd_st == bms_pkg::bms_c_load);
    assign tx_valid = (cmd_st == bms_pkg::bms_c_read);
    assign rx_hs = rx_valid && rx_ready;
    assign tx_hs = tx_valid && tx_ready;

    // command sequencer; result pulses last one cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cmd_st <= bms_pkg::bms_c_cbw;
            remaining <= 32'h0000_0000;
            cmd_done <= 1'b0;
            cmd_vendor <= 1'b0;
            cmd_fail <= 1'b0;
            cmd_kind <= bms_pkg::bms_k_none;
            cmd_len <= 32'h0000_0000;
            eep_cmd_valid <= 1'b0;
            eep_cmd_read <= 1'b0;
            eep_cmd_len <= 8'h00;
        end else begin
            cmd_done <= 1'b0;
            eep_cmd_valid <= 1'b0;
            case (cmd_st)
                bms_pkg::bms_c_cbw: begin
                    if (cbw_end) begin
                        cmd_st <= bms_pkg::bms_c_dec;
                    end
                end
                bms_pkg::bms_c_dec: begin
                    cmd_len <= xfer_len;
                    remaining <= xfer_len;
                    cmd_vendor <= is_vendor;
                    cmd_fail <= is_vendor && !cmd_good;
                    cmd_kind <= (is_vendor && cmd_good) ? next_kind
                        : bms_pkg::bms_k_none;
                    cmd_st <= bms_pkg::bms_c_cbw;
                    if (!is_vendor || !cmd_good) begin
                        cmd_done <= 1'b1;
                    end else begin
                        if (is_cfg) begin
                            eep_cmd_valid <= 1'b1;
                            eep_cmd_read <= dir_in;
                            eep_cmd_len <= xfer_len[7:0];
                        end
                        if (xfer_len == 32'h0000_0000
                            || next_kind == bms_pkg::bms_k_cfg_read) begin
                            cmd_done <= 1'b1;
                        end else if (dir_in) begin
                            cmd_st <= bms_pkg::bms_c_read;
                        end else begin
                            cmd_st <= bms_pkg::bms_c_load;
                        end
                    end
                end
                bms_pkg::bms_c_load, bms_pkg::bms_c_read: begin
                    if (rx_hs || tx_hs) begin
                        remaining <= remaining - 32'h0000_0001;
                        if (remaining == 32'h0000_0001) begin
                            cmd_done <= 1'b1;
                            cmd_st <= bms_pkg::bms_c_cbw;
                        end
                    end
                end
                default: cmd_st <= bms_pkg::bms_c_cbw;
            endcase
        end
    end

    // test takeover is sticky like the mode itself
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_test_active <= 1'b0;
        end else if (cmd_st == bms_pkg::bms_c_dec && is_vendor && cmd_good
            && next_kind == bms_pkg::bms_k_pin_load) begin
            pin_test_active <= 1'b1;
        end
    end

    // live snapshot: mode flag replaces the select pin, load-only bit 15 reads as 0
    always_comb begin
        live_snap = pin_s2;
        live_snap[`BMS_IMG_MFG_SEL] = mfg_mode;
        live_snap[`BMS_IMG_DD_OE] = 1'b0;
    end

    // payload byte index saturates so long transfers never wrap
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            byte_idx <= 3'h0;
            snap <= 32'h0000_0000;
            tx_byte <= 8'h00;
        end else if (cmd_st == bms_pkg::bms_c_dec) begin
            byte_idx <= 3'h0;
            snap <= live_snap;
            tx_byte <= snap_byte(live_snap, 3'h0);
        end else if (rx_hs || tx_hs) begin
            if (byte_idx != 3'h4) begin
                byte_idx <= byte_idx + 3'h1;
            end
            tx_byte <= snap_byte(snap, byte_idx + 3'h1);
        end
    end

    // payload to eeprom engine or to the test image
    assign pin_load = rx_hs && cmd_kind == bms_pkg::bms_k_pin_load
        && 32'(byte_idx) < PIN_BYTES;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            eep_wr_valid <= 1'b0;
            eep_wr_byte <= 8'h00;
        end else begin
            eep_wr_valid <= rx_hs && cmd_kind == bms_pkg::bms_k_cfg_load;
            eep_wr_byte <= rx_byte;
        end
    end

    bms_pin_ctrl u_pins (
        .clk_sys(clk_sys),
        .srst(srst),
        .load_valid(pin_load),
        .load_idx(byte_idx[1:0]),
        .load_byte(rx_byte),
        .test_active(pin_test_active),
        .norm_ctl(norm_ctl),
        .norm_ctl_oe(norm_ctl_oe),
        .norm_dd(norm_dd),
        .norm_dd_oe(norm_dd_oe),
        .ctl_out(ctl_out),
        .ctl_oe(ctl_oe),
        .dd_out(dd_out),
        .dd_oe(dd_oe)
    );

    default clocking cb_clk @(posedge clk_sys); endclocking
    default disable iff (srst);
    AST_MFG_STICKY: assert property (mfg_mode |=> mfg_mode)
        else $error("manufacturing mode left without reset");
    AST_ENUM_GATED: assert property ($rose(usb_enum_en)
        |-> $past(eep_probe_done))
        else $error("enumeration enabled before probe result");
    AST_STRAP: assert property (decide && !strap_ok |=> mfg_mode)
        else $error("low reset strap did not force test mode");
    AST_FUSE: assert property (decide && !eep_present
        |=> cfg_from_fuse && !cfg_from_eeprom)
        else $error("missing eeprom did not select fuses");
    AST_LEGACY: assert property (decide && eep_present && sig_leg
        |=> legacy_pinout && cfg_from_eeprom)
        else $error("legacy signature not honoured");
    AST_NORMAL: assert property (decide && eep_present && sig_norm
        && strap_ok |=> cfg_from_eeprom && !mfg_mode)
        else $error("normal signature did not give normal mode");
    AST_BAD_SIG: assert property (decide && eep_present && !sig_norm
        && !sig_leg |=> mfg_mode)
        else $error("invalid signature did not force test mode");
    AST_BLANK: assert property (decide && !eep_present && fuse_ids_zero
        |=> mfg_mode && default_desc)
        else $error("blank fuses did not force default descriptors");
    AST_CFG_LEN: assert property (cmd_st == bms_pkg::bms_c_dec
        && is_vendor && is_cfg && xfer_len > `BMS_CFG_MAX_LEN
        |=> cmd_done && cmd_fail)
        else $error("oversized config transfer not failed");
    AST_NOT_MFG: assert property (cmd_st == bms_pkg::bms_c_dec
        && !mfg_mode |=> cmd_done && !cmd_vendor && !eep_cmd_valid)
        else $error("vendor command taken outside test mode");
    AST_PIN_ENTRY: assert property (cmd_st == bms_pkg::bms_c_dec
        && is_vendor && !is_cfg && pin_ok && !dir_in
        |=> pin_test_active ##1 ctl_oe == 9'h1ff)
        else $error("pin load did not take over the pins");
    AST_READ_PAD: assert property (tx_hs && byte_idx >= 3'h3
        |=> tx_byte == 8'h00)
        else $error("read bytes past the snapshot not zero");
endmodule

// >>> tb/bms_host_model.sv
// usb host model: sends bulk-only wrappers, then moves the data stage
// assumes the bridge handshakes on rising edges of clk_sys
`timescale 1ns/10ps
module bms_host_model (
    // clock
    input wire logic clk_sys,
    // from the bridge
    input wire logic cbw_ready,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic cmd_done,
    // to the bridge
    output logic cbw_valid,
    output logic cbw_first,
    output logic [7:0] cbw_byte,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic tx_ready
);
    logic [7:0] pay [8];
    logic [7:0] got [8];
    int cnt;
    bit tout;

    // idle lines at time zero
    initial begin
        cbw_valid = 1'b0;
        cbw_first = 1'b0;
        cbw_byte = 8'h00;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end

    // one command; entered 1 ns after an edge, leaves 1 ns after cmd_done
    task automatic xfer(input logic [7:0] dsg, input logic [7:0] sub,
        input logic [7:0] rsv, input logic [31:0] len, input logic dir);
        logic [7:0] w [31];
        int n;
        int t;
        foreach (w[i]) w[i] = 8'h00;
        {w[11], w[10], w[9], w[8]} = len;
        w[12] = {dir, 7'h00};
        w[14] = 8'h10;
        w[15] = dsg;
        w[16] = sub;
        w[17] = rsv;
        w[18] = (sub == 8'h26) ? 8'h02 : 8'h00;
        n = 0;
        t = 0;
        cnt = 0;
        tout = 1'b0;
        for (int i = 0; i < 31; i++) begin
            cbw_valid = 1'b1;
            cbw_first = (i == 0);
            cbw_byte = w[i];
            #1;
            while (!cbw_ready && t < 100) begin
                @(posedge clk_sys);
                #2;
                t++;
            end
            tout = tout || !cbw_ready;
            @(posedge clk_sys);
            #1;
        end
        // released data lines do not keep their last value, except rx_byte when the task returns
        cbw_valid = 1'b0;
        cbw_first = 1'b0;
        cbw_byte = ~cbw_byte;
        while (!tout) begin
            rx_valid = !dir && n < len;
            rx_byte = rx_valid ? pay[n % 8] : ~rx_byte;
            tx_ready = dir;
            #1;
            if (rx_valid && rx_ready)
                n++;
            if (tx_valid && tx_ready) begin
                got[cnt % 8] = tx_byte;
                cnt++;
            end
            @(posedge clk_sys);
            #1;
            if (cmd_done)
                break;
            t++;
            tout = (t > 3000);
        end
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    endtask
endmodule

// >>> tb/boot_mode_select_and_mfg_test_tb.sv
// bench for boot mode selection and the manufacturing test commands
// assumes bms_top and bms_host_model, 4 ns clock
`timescale 1ns/10ps
module boot_mode_select_and_mfg_test_tb;
    logic clk_sys, srst, eep_probe_req, eep_probe_done, eep_present;
    logic fuse_ids_zero, ata_reset_line_n_in, boot_done, usb_enum_en;
    logic cfg_from_eeprom, cfg_from_fuse, legacy_pinout, default_desc;
    logic mfg_mode, pin_test_active, cbw_valid, cbw_first, cbw_ready;
    logic cmd_done, cmd_vendor, cmd_fail, eep_cmd_valid, eep_cmd_read;
    logic eep_wr_valid, rx_valid, rx_ready, tx_valid, tx_ready, norm_dd_oe;
    logic dd_oe;
    logic [7:0] cbw_byte, vendor_command_designator, eep_cmd_len;
    logic [7:0] eep_wr_byte, rx_byte, tx_byte, dsg;
    logic [8:0] norm_ctl, norm_ctl_oe, ctl_out, ctl_oe;
    logic [15:0] eep_signature, norm_dd, dd_out, s, img;
    logic [31:0] sample_pins_in, cmd_len, snap;
    bms_pkg::bms_kind_t cmd_kind;
    int errors, total_checks, wr_cnt;

    bms_top #(.LEGACY_OK(1'b1), .PIN_BYTES(4)) dut (.*);
    bms_host_model host (.*);

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // count and check bytes handed to the eeprom engine
    always @(posedge clk_sys) begin
        if (eep_wr_valid) begin
            chk("eep_wr_byte", eep_wr_byte, host.pay[wr_cnt % 8]);
            wr_cnt++;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] d, input logic [7:0] sub,
        input logic [7:0] rsv, input logic [31:0] len, input logic dir);
        wr_cnt = 0;
        host.xfer(d, sub, rsv, len, dir);
        if (host.tout) begin
            errors++;
            end_of_test();
        end
    endtask

    // reset, answer the probe, then try a vendor command
    task automatic boot(input logic pr, input logic [15:0] sig,
        input logic fz, input logic strap);
        int t;
        logic m;
        srst = 1'b1;
        ata_reset_line_n_in = strap;
        repeat (6) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        t = 0;
        while (!eep_probe_req && t < 50) begin
            @(posedge clk_sys);
            #1;
            t++;
        end
        chk("probe_req", eep_probe_req, 1);
        if (!eep_probe_req)
            end_of_test();
        chk("usb_enum_en", usb_enum_en, 0);
        eep_probe_done = 1'b1;
        eep_present = pr;
        eep_signature = sig;
        fuse_ids_zero = fz;
        @(posedge clk_sys);
        #1;
        eep_probe_done = 1'b0;
        m = !strap || (pr && sig != 16'h534b && sig != 16'h4d4d) || (!pr && fz);
        chk("boot_done", boot_done, 1);
        chk("usb_enum_en", usb_enum_en, 1);
        chk("mfg_mode", mfg_mode, m);
        chk("cfg_from_fuse", cfg_from_fuse, !pr);
        chk("legacy_pinout", legacy_pinout, pr && sig == 16'h4d4d);
        chk("default_desc", default_desc, !pr && fz);
        chk("cfg_eeprom", cfg_from_eeprom,
            pr && (sig == 16'h534b || sig == 16'h4d4d));
        // no test image yet: the bridge still owns every pin
        chk("ctl_out", ctl_out, norm_ctl);
        chk("ctl_oe", ctl_oe, norm_ctl_oe);
        chk("dd_out", dd_out, norm_dd);
        chk("dd_oe", dd_oe, norm_dd_oe);
        cmd(dsg, 8'h27, 8'h00, 32'h0, 1'b0);
        chk("cmd_vendor", cmd_vendor, m);
    endtask

    // main sequence
    initial begin
        srst = 1'b1;
        {eep_probe_done, eep_present, fuse_ids_zero} = 3'h0;
        eep_signature = 16'h0000;
        ata_reset_line_n_in = 1'b1;
        void'($urandom(2));
        dsg = $urandom;
        vendor_command_designator = dsg;
        sample_pins_in = $urandom;
        {norm_ctl, norm_ctl_oe, norm_dd} = $urandom;
        norm_dd_oe = 1'b1;
        boot(1'b1, 16'h534b, 1'b0, 1'b0);
        boot(1'b1, 16'h534b, 1'b0, 1'b1);
        boot(1'b1, 16'h4d4d, 1'b0, 1'b1);
        boot(1'b0, 16'h0000, 1'b0, 1'b1);
        boot(1'b0, 16'h0000, 1'b1, 1'b1);
        do
            s = $urandom;
        while (s == 16'h534b || s == 16'h4d4d);
        boot(1'b1, s, 1'b0, 1'b1);
        // wrong designator, bad fixed field, oversize load
        cmd(~dsg, 8'h27, 8'h00, 32'h4, 1'b0);
        chk("cmd_vendor", cmd_vendor, 0);
        cmd(dsg, 8'h26, 8'h01, 32'h10, 1'b0);
        chk("cmd_fail", cmd_fail, 1);
        cmd(dsg, 8'h26, 8'h00, 32'h100, 1'b0);
        chk("cmd_fail", cmd_fail, 1);
        chk("cmd_kind", cmd_kind, bms_pkg::bms_k_none);
        // largest legal load, then a read
        foreach (host.pay[j]) host.pay[j] = $urandom;
        cmd(dsg, 8'h26, 8'h00, 32'hff, 1'b0);
        @(posedge clk_sys);
        #1;
        chk("cmd_kind", cmd_kind, bms_pkg::bms_k_cfg_load);
        chk("eep_wr count", wr_cnt, 255);
        chk("eep_cmd_len", eep_cmd_len, 8'hff);
        chk("cmd_len", cmd_len, 32'hff);
        cmd(dsg, 8'h26, 8'h00, 32'h10, 1'b1);
        chk("eep_cmd_valid", eep_cmd_valid, 1);
        chk("eep_cmd_read", eep_cmd_read, 1);
        chk("cmd_kind", cmd_kind, bms_pkg::bms_k_cfg_read);
        // pin loads: six bytes with drivers on, four with them off
        for (int i = 0; i < 2; i++) begin
            foreach (host.pay[j]) host.pay[j] = $urandom;
            host.pay[1][7] = (i == 0);
            cmd(dsg, 8'h27, 8'h00, 32'h6 - 2 * i, 1'b0);
            repeat (2) @(posedge clk_sys);
            #1;
            img = {host.pay[1], host.pay[0]};
            chk("cmd_kind", cmd_kind, bms_pkg::bms_k_pin_load);
            chk("pin_test_active", pin_test_active, 1);
            chk("ctl_oe", ctl_oe, 9'h1ff);
            chk("ctl_out", ctl_out, {img[8], img[9], img[10], img[2],
                img[1], img[3], img[5], img[4], img[7]});
            chk("dd_oe", dd_oe, i == 0);
            chk("dd_out", dd_out, {host.pay[3], host.pay[2]});
        end
        // pin read of six bytes
        sample_pins_in = $urandom;
        cmd(dsg, 8'h27, 8'h00, 32'h6, 1'b1);
        snap = sample_pins_in;
        snap[15:14] = 2'h1;
        for (int j = 0; j < 6; j++)
            chk("tx_byte", host.got[j], j < 4 ? snap[8*j +: 8] : 8'h00);
        chk("tx count", host.cnt, 6);
        chk("mfg_mode", mfg_mode, 1);
        end_of_test();
    end
endmodule
